//--- core/calib_regs.svh
`ifndef CALIB_REGS_SVH
`define CALIB_REGS_SVH

`define ADDR_IDEAL_FACTOR 8'h14
`define ADDR_IDEAL_SEL 8'h15
`define ADDR_OFS_VAL 8'h16
`define ADDR_OFS_SEL 8'h17
`define ADDR_FILT_SEL 8'h18

`define RST_IDEAL_FACTOR 8'h18
`define RST_OFS_VAL 8'h77
`define RST_CH_SEL 8'h00
`define RST_READ 8'h00

`define CH_BIT_MASK 8'h0e
`define OFS_ZERO_CODE 16'h0077
`define OFS_UNIT_SHIFT 5
`define OFS_STEP_CODE 8'h78
`define OFS_STEP_UNITS 16'sh0020
`define TEMP_STEP_GUARD 16'sh7000
`define TEMP_MAX 16'sh7fff
`define TEMP_MIN 16'sh8000
`define CH_ONE 4'h1

`endif

//--- core/calib_pkg.sv
package calib_pkg;

    typedef logic signed [15:0] temp_t;
    typedef logic [3:0][15:0] temp_vec_t;

    typedef struct packed {
        logic use_custom;
        logic [7:0] ideal_code;
        logic ofs_en;
        logic filt_en;
        logic [7:0] ofs_val;
        logic [1:0] ch;
    } conv_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } conv_state_t;

endpackage

//--- core/calib_slot.sv
`timescale 1ns/1ps
module calib_slot
    import calib_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic filt_i,
    input wire logic [15:0] raw_i,
    input wire logic [15:0] ref_i,
    output logic [15:0] temp_o,
    output logic signed [16:0] delta_o,
    output logic primed_o
);

    logic signed [16:0] avg_sum;
    logic [15:0] temp_next;

    // first sample after reset has no history, so it passes unfiltered
    always_comb begin
        avg_sum = {temp_o[15], temp_o} + {raw_i[15], raw_i};
        temp_next = raw_i;
        if (filt_i && primed_o) begin
            temp_next = avg_sum[16:1];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            temp_o <= '0;
            primed_o <= 1'b0;
        end else if (load_i) begin
            temp_o <= temp_next;
            primed_o <= 1'b1;
        end
    end

    assign delta_o = {temp_o[15], temp_o} - {ref_i[15], ref_i};

endmodule

//--- core/calib_core.sv
// Contract
// R1: a remote channel uses ideality 1.008 when its select bit is 0, else the programmable factor.
// R2: ideality select bits 3,2,1 map to channels 3,2,1, other bits reserved, reset 00h.
// R3: the offset code counts eighths of a degree from -14.875 degrees.
// R4: the offset register resets to 77h, zero offset, spanning -14.875 to +17 degrees.
// R5: the offset is added only to channels whose offset enable bit 3,2,1 is set, reset 00h.
// R6: the highest temperature is computed without the custom offset.
// R7: noise filtering acts on a channel only when its filter bit is set, reset 00h.
// R8: the programmable ideality factor is its own read/write register, reset 18h.
// R9: the highest value is the largest selected channel temperature minus its reference.
// R10: settings changes take effect at the next conversion of a channel, never mid-conversion.
`timescale 1ns/1ps
`include "calib_regs.svh"
module calib_core
    import calib_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    input wire logic CONV_START_I,
    input wire logic [1:0] CONV_CH_I,
    input wire logic RESULT_VALID_I,
    input wire logic [15:0] RESULT_TEMP_I,
    input wire logic [3:0] HIGH_SEL_I,
    input wire temp_vec_t REF_TEMP_I,
    output logic CONV_BUSY_O,
    output logic IDEAL_CUSTOM_O,
    output logic [7:0] IDEAL_CODE_O,
    output logic TEMP_VALID_O,
    output logic [1:0] TEMP_CH_O,
    output logic [15:0] TEMP_O,
    output logic [15:0] HIGHEST_O
);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] ideal_factor_reg;
    logic [7:0] ideal_sel_reg;
    logic [7:0] ofs_val_reg;
    logic [7:0] ofs_sel_reg;
    logic [7:0] filt_sel_reg;
    logic [7:0] rdata_next;

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ideal_factor_reg <= `RST_IDEAL_FACTOR; // [R8]
            ideal_sel_reg <= `RST_CH_SEL; // [R2]
            ofs_val_reg <= `RST_OFS_VAL; // [R4]
            ofs_sel_reg <= `RST_CH_SEL; // [R5]
            filt_sel_reg <= `RST_CH_SEL; // [R7]
        end else if (REG_WR_I) begin
            unique case (REG_ADDR_I)
                `ADDR_IDEAL_FACTOR: ideal_factor_reg <= REG_WDATA_I; // [R8]
                `ADDR_IDEAL_SEL: begin
                    ideal_sel_reg <= REG_WDATA_I & `CH_BIT_MASK; // [R2]
                end
                `ADDR_OFS_VAL: ofs_val_reg <= REG_WDATA_I; // [R3]
                `ADDR_OFS_SEL: begin
                    ofs_sel_reg <= REG_WDATA_I & `CH_BIT_MASK; // [R5]
                end
                `ADDR_FILT_SEL: begin
                    filt_sel_reg <= REG_WDATA_I & `CH_BIT_MASK; // [R7]
                end
                default: ;
            endcase
        end
    end

    // unmapped addresses read as zero
    always_comb begin
        rdata_next = `RST_READ;
        unique case (REG_ADDR_I)
            `ADDR_IDEAL_FACTOR: rdata_next = ideal_factor_reg;
            `ADDR_IDEAL_SEL: rdata_next = ideal_sel_reg;
            `ADDR_OFS_VAL: rdata_next = ofs_val_reg;
            `ADDR_OFS_SEL: rdata_next = ofs_sel_reg;
            `ADDR_FILT_SEL: rdata_next = filt_sel_reg;
            default: rdata_next = `RST_READ;
        endcase
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            REG_RDATA_O <= `RST_READ;
        end else if (REG_RD_I) begin
            REG_RDATA_O <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    conv_state_t state_reg;
    conv_cfg_t cfg_reg;
    logic start_take;
    logic res_take;
    logic sel_bit;

    assign start_take = CONV_START_I && (state_reg == ST_IDLE);
    assign res_take = RESULT_VALID_I && (state_reg == ST_CONV);
    assign sel_bit = ideal_sel_reg[CONV_CH_I];

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: if (start_take) state_reg <= ST_CONV;
                ST_CONV: if (res_take) state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // settings frozen per conversion so a write cannot tear one apart
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cfg_reg <= '0;
            CONV_BUSY_O <= 1'b0;
            IDEAL_CUSTOM_O <= 1'b0;
            IDEAL_CODE_O <= `RST_IDEAL_FACTOR;
        end else begin
            CONV_BUSY_O <= (state_reg == ST_IDLE) ? start_take : !res_take;
            if (start_take) begin
                cfg_reg.use_custom <= sel_bit; // [R1] [R10]
                cfg_reg.ideal_code <= ideal_factor_reg; // [R8]
                cfg_reg.ofs_en <= ofs_sel_reg[CONV_CH_I]; // [R5]
                cfg_reg.filt_en <= filt_sel_reg[CONV_CH_I]; // [R7]
                cfg_reg.ofs_val <= ofs_val_reg; // [R10]
                cfg_reg.ch <= CONV_CH_I;
                IDEAL_CUSTOM_O <= sel_bit; // [R1]
                IDEAL_CODE_O <= ideal_factor_reg; // [R1]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [3:0][15:0] slot_temp;
    logic signed [3:0][16:0] slot_delta;
    logic [3:0] slot_primed;

    for (genvar g = 0; g < 4; g++) begin : g_slot
        calib_slot u_slot (
            .clk_i(MCLK_I),
            .rst_n_i(RST_N_I),
            .load_i(res_take && (cfg_reg.ch == 2'(g))),
            .filt_i(cfg_reg.filt_en), // [R7]
            .raw_i(RESULT_TEMP_I),
            .ref_i(REF_TEMP_I[g]),
            .temp_o(slot_temp[g]),
            .delta_o(slot_delta[g]),
            .primed_o(slot_primed[g])
        );
    end

    logic pipe_valid_reg;
    logic pipe_ofs_en_reg;
    logic [1:0] pipe_ch_reg;
    logic [15:0] pipe_units_reg;
    logic [15:0] ofs_units;

    // eighths of a degree, biased so that 77h is zero
    assign ofs_units = ({8'h00, cfg_reg.ofs_val} - `OFS_ZERO_CODE)
        << `OFS_UNIT_SHIFT; // [R3]

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pipe_valid_reg <= 1'b0;
            pipe_ofs_en_reg <= 1'b0;
            pipe_ch_reg <= '0;
            pipe_units_reg <= '0;
        end else begin
            pipe_valid_reg <= res_take;
            if (res_take) begin
                pipe_ofs_en_reg <= cfg_reg.ofs_en; // [R5]
                pipe_ch_reg <= cfg_reg.ch;
                pipe_units_reg <= ofs_units; // [R3]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] sel_temp;
    logic signed [16:0] ofs_sum;
    logic [15:0] temp_next;
    logic signed [16:0] high_max;
    logic high_any;

    always_comb begin
        sel_temp = slot_temp[pipe_ch_reg];
        ofs_sum = {sel_temp[15], sel_temp} + {pipe_units_reg[15], pipe_units_reg};
        temp_next = sel_temp;
        if (pipe_ofs_en_reg) begin
            // saturate rather than wrap at the format's ends
            if (ofs_sum[16] != ofs_sum[15]) begin
                temp_next = ofs_sum[16] ? `TEMP_MIN : `TEMP_MAX;
            end else begin
                temp_next = ofs_sum[15:0]; // [R5]
            end
        end
    end

    // slots hold unoffset values, so the offset never reaches the max
    always_comb begin
        high_max = '0;
        high_any = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (HIGH_SEL_I[i] && slot_primed[i]) begin
                // element select drops the sign, so compare as signed
                if (!high_any || $signed(slot_delta[i]) > high_max) begin
                    high_max = $signed(slot_delta[i]); // [R6] [R9]
                end
                high_any = 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            TEMP_VALID_O <= 1'b0;
            TEMP_CH_O <= '0;
            TEMP_O <= '0;
            HIGHEST_O <= '0;
        end else begin
            TEMP_VALID_O <= pipe_valid_reg;
            if (pipe_valid_reg) begin
                TEMP_CH_O <= pipe_ch_reg;
                TEMP_O <= temp_next; // [R5]
                HIGHEST_O <= high_max[15:0]; // [R9]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] ref_sel;
    logic only_ch;

    assign ref_sel = REF_TEMP_I[cfg_reg.ch];
    assign only_ch = (HIGH_SEL_I == (`CH_ONE << cfg_reg.ch));

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);

    sequence s_result_plain;
        res_take && !cfg_reg.filt_en;
    endsequence

    a_ideal_select: assert property ( // [R1]
        start_take |=> IDEAL_CUSTOM_O == $past(sel_bit)
    ) else $error("ideality select not taken from channel bit");

    a_ideal_code: assert property ( // [R8]
        start_take |=> IDEAL_CODE_O == $past(ideal_factor_reg)
    ) else $error("ideality factor not passed to conversion");

    a_sel_reserved: assert property ( // [R2]
        ((ideal_sel_reg | ofs_sel_reg | filt_sel_reg) & ~`CH_BIT_MASK) == '0
    ) else $error("reserved select bit set");

    a_busy_hold: assert property ( // [R10]
        CONV_BUSY_O && !res_take |=> $stable(IDEAL_CODE_O) &&
            $stable(IDEAL_CUSTOM_O) && $stable(cfg_reg)
    ) else $error("settings changed during conversion");

    a_ofs_off: assert property ( // [R5]
        s_result_plain and !cfg_reg.ofs_en
            |-> ##2 TEMP_VALID_O && TEMP_O == $past(RESULT_TEMP_I, 2)
    ) else $error("offset applied to disabled channel");

    a_ofs_step: assert property ( // [R3]
        s_result_plain and cfg_reg.ofs_en and
            cfg_reg.ofs_val == `OFS_STEP_CODE and
            $signed(RESULT_TEMP_I) < `TEMP_STEP_GUARD
            |-> ##2 TEMP_O == $past(RESULT_TEMP_I, 2) + `OFS_STEP_UNITS
    ) else $error("offset scale wrong");

    a_high_delta: assert property ( // [R6]
        s_result_plain and only_ch |-> ##2
            HIGHEST_O == $past(RESULT_TEMP_I, 2) - $past(ref_sel, 2)
    ) else $error("highest value wrong or offset included");

    a_read_latency: assert property ( // [R4]
        REG_RD_I && REG_ADDR_I == `ADDR_OFS_VAL
            |=> REG_RDATA_O == $past(ofs_val_reg)
    ) else $error("offset register read mismatch");

endmodule

//--- testbench/conv_model.sv
`timescale 1ns/1ps
module conv_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [1:0] ch_i,
    input wire logic [15:0] raw_i,
    input wire logic [3:0] lat_i,
    output logic start_o,
    output logic [1:0] ch_o,
    output logic valid_o,
    output logic [15:0] temp_o
);
    initial begin
        start_o = 1'b0;
        ch_o = 2'h0;
        valid_o = 1'b0;
        temp_o = 16'ha5a5;
    end
    ////////////////////////////////////////////////////////////////////
    // one conversion per request, result after lat_i cycles
    always @(posedge go_i) begin
        start_o = 1'b1;
        ch_o = ch_i;
        @(posedge clk_i) #1;
        start_o = 1'b0;
        ch_o = ~ch_i;
        repeat (lat_i) @(posedge clk_i);
        #1;
        valid_o = 1'b1;
        temp_o = raw_i;
        @(posedge clk_i) #1;
        valid_o = 1'b0;
        // released bus must not keep the old value
        temp_o = ~raw_i;
    end
endmodule

//--- testbench/remote_channel_calibration_regs_bench.sv
`timescale 1ns/1ps
module remote_channel_calibration_regs_bench import calib_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic go = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [3:0] hsel = 4'h2;
    logic [3:0] lat = 4'h0;
    logic [1:0] gch = 2'h0;
    logic [15:0] graw = 16'h0000;
    temp_vec_t ref_t = {16'h0000, 16'h0000, 16'h0100, 16'h0000};
    logic [7:0] rdata;
    logic [7:0] icode;
    logic [1:0] mch;
    logic [1:0] tch;
    logic [15:0] mtemp;
    logic [15:0] temp;
    logic [15:0] high;
    logic start, rvalid, busy, icust, tvalid;
    int mismatches = 0;
    int samples_checked = 0;
    always #10 clk = ~clk;
    ////////////////////////////////////////////////////////////////////
    calib_core dut_u (.MCLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .CONV_START_I(start), .CONV_CH_I(mch),
        .RESULT_VALID_I(rvalid), .RESULT_TEMP_I(mtemp), .HIGH_SEL_I(hsel),
        .REF_TEMP_I(ref_t), .CONV_BUSY_O(busy), .IDEAL_CUSTOM_O(icust),
        .IDEAL_CODE_O(icode), .TEMP_VALID_O(tvalid), .TEMP_CH_O(tch),
        .TEMP_O(temp), .HIGHEST_O(high));
    conv_model conv_u (.clk_i(clk), .go_i(go), .ch_i(gch), .raw_i(graw),
        .lat_i(lat), .start_o(start), .ch_o(mch), .valid_o(rvalid),
        .temp_o(mtemp));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exv);
        samples_checked++;
        if (got !== exv) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exv);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk) #1;
        wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) #1;
        addr = a;
        rd = 1'b1;
        @(posedge clk) #1;
        rd = 1'b0;
        @(posedge clk) #1;
        chk({8'h00, rdata}, {8'h00, e});
    endtask
    task automatic conv_go(input logic [1:0] c, input logic [15:0] r,
                           input logic [3:0] l);
        gch = c;
        graw = r;
        lat = l;
        go = 1'b1;
    endtask
    // bounded wait, a lost result counts as a mismatch
    // always steps one edge first so a stale valid pulse is not taken
    task automatic conv_wait();
        int n;
        n = 0;
        do begin
            @(posedge clk) #1;
            go = 1'b0;
            n++;
        end while (tvalid !== 1'b1 && n < 60);
        if (tvalid !== 1'b1) mismatches++;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] sa [3] = '{8'h15, 8'h17, 8'h18};
        chk({8'h00, icode}, 16'h0018);
        rd_chk(8'h14, 8'h18);
        rd_chk(8'h16, 8'h77);
        rd_chk(8'h20, 8'h00);
        wr_reg(8'h20, 8'h5a);
        rd_chk(8'h20, 8'h00);
        for (int i = 0; i < 3; i++) begin
            rd_chk(sa[i], 8'h00);
            wr_reg(sa[i], 8'hff);
            rd_chk(sa[i], 8'h0e);
            wr_reg(sa[i], 8'h00);
        end
    endtask
    task automatic t_ideal();
        wr_reg(8'h14, 8'h33);
        for (int c = 1; c < 4; c++) begin
            wr_reg(8'h15, 8'h0e);
            conv_go(c[1:0], 16'h0100, 4'd0);
            conv_wait();
            chk({15'h0000, icust}, 16'h0001);
            chk({8'h00, icode}, 16'h0033);
            wr_reg(8'h15, 8'h0e ^ (8'h01 << c));
            conv_go(c[1:0], 16'h0100, 4'd9);
            conv_wait();
            chk({15'h0000, icust}, 16'h0000);
        end
        wr_reg(8'h15, 8'h00);
    endtask
    task automatic t_offset();
        logic [7:0] code [4] = '{8'h00, 8'h77, 8'h78, 8'hff};
        logic [15:0] ofs [4] = '{16'hf120, 16'h0000, 16'h0020, 16'h1100};
        wr_reg(8'h17, 8'h02);
        for (int i = 0; i < 4; i++) begin
            wr_reg(8'h16, code[i]);
            conv_go(2'd1, 16'h0640, 4'd2);
            conv_wait();
            chk(temp, 16'h0640 + ofs[i]);
            chk(high, 16'h0540);
            chk({14'h0000, tch}, 16'h0001);
        end
        hsel = 4'h6;
        conv_go(2'd2, 16'h0640, 4'd0);
        conv_wait();
        chk(temp, 16'h0640);
        chk(high, 16'h0640);
    endtask
    // settings written mid-conversion wait for the next one
    task automatic t_late();
        wr_reg(8'h16, 8'h7f);
        conv_go(2'd1, 16'h0200, 4'd9);
        wr_reg(8'h17, 8'h00);
        chk({15'h0000, busy}, 16'h0001);
        conv_wait();
        chk({15'h0000, busy}, 16'h0000);
        chk(temp, 16'h0300);
        conv_go(2'd1, 16'h0200, 4'd0);
        conv_wait();
        chk(temp, 16'h0200);
    endtask
    task automatic t_filter();
        logic [15:0] raw [4] = '{16'h0400, 16'h0600, 16'h0700, 16'h0200};
        logic [15:0] exv [4] = '{16'h0400, 16'h0500, 16'h0600, 16'h0200};
        @(posedge clk) #1;
        rst_n = 1'b0;
        @(posedge clk) #1;
        rst_n = 1'b1;
        rd_chk(8'h16, 8'h77);
        wr_reg(8'h18, 8'h08);
        for (int i = 0; i < 4; i++) begin
            if (i == 3) wr_reg(8'h18, 8'h00);
            conv_go(2'd3, raw[i], 4'd1);
            conv_wait();
            chk(temp, exv[i]);
        end
        chk(high, 16'h0000);
        // a negative difference must lose against a positive one
        hsel = 4'ha;
        conv_go(2'd1, 16'h0000, 4'd0);
        conv_wait();
        chk(temp, 16'h0000);
        chk(high, 16'h0200);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_regs();
        t_ideal();
        t_offset();
        t_late();
        t_filter();
        tally_and_finish();
    end
    // whole run is under two hundred cycles
    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end
endmodule
